// ### inc/watchdog_cfg.svh
// constants for the watchdog timer block
// How it works
// - mode field 11: watchdog always active, sleep included, enable ignored
// - mode field 10: active while awake, disabled in sleep
// - mode field 01: soft enable decides; sleep does not change it
// - mode field 00: disabled; enable bit ignored at 00 and 1x
// - soft-controlled mode: write 1 turns on, write 0 turns off
// - period code 00000 gives 32 ticks, doubling to 2^23 at 10010
// - codes 10011 to 11111 act as minimum 32 ticks
// - period select resets to 01011, ratio 65536, about two seconds
// - counter advances on slow oscillator ticks, not system clock rate
// - count cleared on reset, clear, sleep in/out, osc fail, disable, startup
// - still enabled in sleep: counting resumes after the entry clear
// - wake with crystal clock: held clear until startup timer ends
// - timeout in sleep wakes the device instead of resetting
// - timeout updates timeout and powerdown status flags
// - watchdog reset also recorded in power control flag
// - changing oscillator divider does not touch the count
// - control bits 7 and 6 read zero; enable bit resets to 0
// - awake timeout resets device; firmware must clear in time
`ifndef WATCHDOG_CFG_SVH
`define WATCHDOG_CFG_SVH
`define WD_CTRL_OFS 12'h000
`define WD_STAT_OFS 12'h004
`define WD_IRQ_STAT_OFS 12'h008
`define WD_IRQ_MASK_OFS 12'h00c
`define WD_PS_LSB 1
`define WD_PS_MSB 5
`define WD_EN_BIT 0
`define WD_PS_RESET 5'h0b
`define WD_PS_MAX 5'h12
`define WD_PS_MIN_LOG2 5
`define WD_CNT_W 24
`define WD_CLK_HZ 250000000
`define WD_LFOSC_HZ 31000
`define WD_TICK_CYCLES ((`WD_CLK_HZ) / (`WD_LFOSC_HZ))
`define WD_MODE_OFF 2'h0
`define WD_MODE_SOFT 2'h1
`define WD_MODE_AWAKE 2'h2
`define WD_MODE_ON 2'h3
`define WD_IRQ_TIMEOUT 0
`define WD_IRQ_WAKE 1
`endif

// ### inc/watchdog_pkg.sv
// types for the watchdog timer block
package watchdog_pkg;
    typedef enum logic [1:0] {
        WD_OFF = 2'b00,
        WD_SOFT = 2'b01,
        WD_AWAKE_ONLY = 2'b10,
        WD_ALWAYS = 2'b11
    } wd_mode_t;
endpackage

// ### rtl/wd_tick_gen.sv
// divider producing the slow oscillator tick enable
`timescale 1ns/1ns
`include "watchdog_cfg.svh"
module wd_tick_gen (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // tick output
    output logic o_tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } tick_state_t;
    localparam logic [15:0] TICK_LAST = 16'(`WD_TICK_CYCLES - 1);
    tick_state_t st_reg, st_next;
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt == TICK_LAST) begin
            st_next.cnt = 16'h0000;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign o_tick = st_reg.tick;
endmodule // wd_tick_gen

// ### rtl/watchdog_timer.sv
// watchdog timer with apb registers and interrupt
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "watchdog_cfg.svh"
module watchdog_timer
    import watchdog_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // configuration and core status
    input wire logic [1:0] i_watchdog_mode_cfg,
    input wire logic i_sleep,
    input wire logic i_clear_watch_instr,
    input wire logic i_osc_fail,
    input wire logic i_osc_startup_timer,
    input wire logic i_crystal_clock,
    // outputs to core
    output logic o_device_reset,
    output logic o_wake,
    output logic o_timeout_flag,
    output logic o_powerdown_flag,
    output logic o_watch_reset_flag,
    output logic o_active,
    output logic o_irq
);
    typedef struct packed {
        logic [4:0] period_select;
        logic soft_watch_enable;
        logic [`WD_CNT_W-1:0] count;
        logic sleep_d;
        logic hold_clear;
        logic timeout_flag;
        logic powerdown_flag;
        logic watch_reset_flag;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic device_reset;
        logic wake;
        logic active;
        logic irq;
    } wd_state_t;

    wd_state_t st_reg, st_next;
    logic tick;
    wd_mode_t mode;
    logic active_now;
    logic clear_now;
    logic [`WD_CNT_W-1:0] ratio_m1;
    logic timeout;
    logic apb_access;
    logic apb_wr;
    logic apb_rd;
    logic [1:0] events;

    wd_tick_gen u_tick (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .o_tick(tick)
    );

    assign mode = wd_mode_t'(i_watchdog_mode_cfg);
    assign apb_access = i_psel && i_penable && !st_reg.pready;
    assign apb_wr = apb_access && i_pwrite;
    assign apb_rd = apb_access && !i_pwrite;

    always_comb begin
        unique case (mode)
            WD_ALWAYS: active_now = 1'b1;
            WD_AWAKE_ONLY: active_now = !i_sleep;
            WD_SOFT: active_now = st_reg.soft_watch_enable;
            WD_OFF: active_now = 1'b0;
        endcase
    end

    // ratio minus one; reserved codes fall back to minimum
    always_comb begin
        ratio_m1 = '0;
        if (st_reg.period_select > `WD_PS_MAX) begin
            ratio_m1 = `WD_CNT_W'((1 << `WD_PS_MIN_LOG2) - 1);
        end else begin
            ratio_m1 = `WD_CNT_W'((32'h1 << (st_reg.period_select
                + 5'(`WD_PS_MIN_LOG2))) - 32'h1);
        end
    end

    // sleep entry, wake, osc fail, disable, startup timer all clear
    assign clear_now = i_clear_watch_instr || i_osc_fail || !active_now
        || (i_sleep != st_reg.sleep_d)
        || (st_reg.hold_clear && i_osc_startup_timer);

    // at or past the ratio: a shortened period must still expire
    assign timeout = !clear_now && tick && (st_reg.count >= ratio_m1);
    assign events = {timeout && st_reg.sleep_d, timeout};

    always_comb begin
        st_next = st_reg;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.device_reset = 1'b0;
        st_next.wake = 1'b0;
        st_next.sleep_d = i_sleep;
        // crystal wake: hold until the startup timer drops
        if (st_reg.sleep_d && !i_sleep) begin
            st_next.hold_clear = i_crystal_clock;
        end else if (!i_osc_startup_timer) begin
            st_next.hold_clear = 1'b0;
        end
        // counter advances on slow ticks only; divider changes ignored
        if (clear_now) begin
            st_next.count = '0;
        end else if (timeout) begin
            st_next.count = '0;
        end else if (tick) begin
            st_next.count = st_reg.count + `WD_CNT_W'(1);
        end
        if (i_clear_watch_instr) begin
            st_next.timeout_flag = 1'b0;
            st_next.powerdown_flag = 1'b0;
        end
        if (timeout) begin
            st_next.timeout_flag = 1'b1;
            st_next.powerdown_flag = st_reg.sleep_d;
            if (st_reg.sleep_d) begin
                st_next.wake = 1'b1;
            end else begin
                st_next.device_reset = 1'b1;
                st_next.watch_reset_flag = 1'b1;
            end
        end
        // apb access: answer registered at the access edge, so one wait state
        if (apb_access) begin
            st_next.pready = 1'b1;
            st_next.prdata = 32'h0000_0000;
            unique case (i_paddr)
                `WD_CTRL_OFS: begin
                    if (apb_wr && i_pstrb[0]) begin
                        st_next.period_select =
                            i_pwdata[`WD_PS_MSB:`WD_PS_LSB];
                        st_next.soft_watch_enable =
                            i_pwdata[`WD_EN_BIT];
                    end
                    st_next.prdata = {24'h000000, 2'b00,
                        st_reg.period_select,
                        st_reg.soft_watch_enable};
                end
                `WD_STAT_OFS: begin
                    if (apb_wr && i_pstrb[0] && i_pwdata[2]) begin
                        st_next.watch_reset_flag = timeout
                            && !st_reg.sleep_d;
                    end
                    st_next.prdata = {26'h0, st_reg.active,
                        st_reg.sleep_d, st_reg.watch_reset_flag,
                        st_reg.timeout_flag, st_reg.powerdown_flag, 1'b0};
                end
                `WD_IRQ_STAT_OFS: begin
                    st_next.prdata = {30'h0, st_reg.irq_stat};
                end
                `WD_IRQ_MASK_OFS: begin
                    if (apb_wr && i_pstrb[0]) begin
                        st_next.irq_mask = i_pwdata[1:0];
                    end
                    st_next.prdata = {30'h0, st_reg.irq_mask};
                end
                default: begin
                    st_next.pslverr = 1'b1;
                end
            endcase
        end
        // read clears status; a new event in the same cycle wins
        if (apb_rd && i_paddr == `WD_IRQ_STAT_OFS) begin
            st_next.irq_stat = events;
        end else begin
            st_next.irq_stat = st_reg.irq_stat | events;
        end
        st_next.active = active_now;
        st_next.irq = |(st_next.irq_stat & st_reg.irq_mask);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st_reg <= '0;
            st_reg.period_select <= `WD_PS_RESET;
            st_reg.soft_watch_enable <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_prdata = st_reg.prdata;
    assign o_pready = st_reg.pready;
    assign o_pslverr = st_reg.pslverr;
    assign o_device_reset = st_reg.device_reset;
    assign o_wake = st_reg.wake;
    assign o_timeout_flag = st_reg.timeout_flag;
    assign o_powerdown_flag = st_reg.powerdown_flag;
    assign o_watch_reset_flag = st_reg.watch_reset_flag;
    assign o_active = st_reg.active;
    assign o_irq = st_reg.irq;
endmodule // watchdog_timer

// ### test/watchdog_timer_assertions.sv
// port checker for the watchdog timer
`timescale 1ns/1ns
module watchdog_timer_checker (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // watched ports
    input wire logic [1:0] i_watchdog_mode_cfg,
    input wire logic i_sleep,
    input wire logic o_device_reset,
    input wire logic o_wake,
    input wire logic o_timeout_flag,
    input wire logic o_watch_reset_flag,
    input wire logic o_active
);
    logic [1:0] md;
    logic tmo;
    assign md = i_watchdog_mode_cfg;
    assign tmo = o_device_reset | o_wake;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);
    property p_on; (md == 2'h3) [*3] |-> o_active; endproperty
    a_on: assert property (p_on) else $error("always mode idle");
    property p_awake; (md == 2'h2 && !i_sleep) [*3] |-> o_active; endproperty
    a_awake: assert property (p_awake) else $error("awake idle");
    property p_slp; (md == 2'h2 && i_sleep) [*3] |-> !o_active; endproperty
    a_slp: assert property (p_slp) else $error("sleep running");
    property p_off; (md == 2'h0) [*3] |-> !o_active && !tmo; endproperty
    a_off: assert property (p_off) else $error("off mode runs");
    property p_flag; tmo |-> o_timeout_flag; endproperty
    a_flag: assert property (p_flag) else $error("flag missing");
    property p_wrst; o_device_reset |-> o_watch_reset_flag; endproperty
    a_wrst: assert property (p_wrst) else $error("reset unrecorded");
    property p_excl; o_wake |-> !o_device_reset; endproperty
    a_excl: assert property (p_excl) else $error("reset in sleep");
    property p_gap; tmo |=> !tmo [*8]; endproperty
    a_gap: assert property (p_gap) else $error("count not restarted");
endmodule // watchdog_timer_checker
bind watchdog_timer watchdog_timer_checker watchdog_timer_checker_i (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_sleep(i_sleep),
    .i_watchdog_mode_cfg(i_watchdog_mode_cfg), .o_wake(o_wake),
    .o_device_reset(o_device_reset), .o_timeout_flag(o_timeout_flag),
    .o_watch_reset_flag(o_watch_reset_flag), .o_active(o_active)
);

// ### test/core_model.sv
// core stand-in: sleep, clear instruction and start-up timer
`timescale 1ns/1ns
module core_model #(
    parameter int STARTUP_CYCLES = 16
) (
    // clock and commands
    input wire logic i_core_clk,
    input wire logic i_sleep_req,
    input wire logic i_kick,
    input wire logic i_wake,
    // status to the watchdog
    output logic o_sleep = 1'b0,
    output logic o_clear = 1'b0,
    output logic o_osc_startup_timer
);
    int ost_cnt = 0;
    logic hold = 1'b0;
    logic nxt;
    assign o_osc_startup_timer = ost_cnt != 0;
    assign nxt = i_sleep_req && !i_wake && !hold;
    always @(posedge i_core_clk) begin
        hold <= i_wake || (hold && i_sleep_req);
        o_clear <= i_kick;
        o_sleep <= nxt;
        if (o_sleep && !nxt) begin
            ost_cnt <= STARTUP_CYCLES;
        end else if (ost_cnt != 0) begin
            ost_cnt <= ost_cnt - 1;
        end
    end
endmodule // core_model

// ### test/tb_top.sv
// self-checking bench for the watchdog timer
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, perr, drst, wake, to_f, pd_f, active, irq, wrst;
    logic [1:0] mode = 2'h0;
    logic sleep_req = 1'b0, kick = 1'b0, sleep, clr, osc_startup_timer;
    int n_fail = 0, n_tests = 0;
    always #2 clk = ~clk;
    watchdog_timer watchdog_timer_i (
        .i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
        .i_watchdog_mode_cfg(mode), .i_sleep(sleep), .i_osc_fail(1'b0),
        .i_clear_watch_instr(clr), .i_osc_startup_timer(osc_startup_timer),
        .i_crystal_clock(1'b1), .o_device_reset(drst), .o_wake(wake),
        .o_timeout_flag(to_f), .o_powerdown_flag(pd_f), .o_irq(irq),
        .o_watch_reset_flag(wrst), .o_active(active));
    core_model core_model_i (
        .i_core_clk(clk), .i_sleep_req(sleep_req), .i_kick(kick),
        .i_wake(wake), .o_sleep(sleep), .o_clear(clr),
        .o_osc_startup_timer(osc_startup_timer));
    task automatic finish_test();
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; read data masked before comparing
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic [31:0] m, input logic [32:0] e);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // only the watchdog process ends a missing answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        check({perr, prdata & m}, e);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_regs();
        apb(1'b0, 12'h000, 32'h0, 32'hffffffff, 33'h16);
        apb(1'b0, 12'h00c, 32'h0, 32'hffffffff, 33'h0);
        apb(1'b1, 12'h000, 32'hff, 32'h0, 33'h0);
        apb(1'b0, 12'h000, 32'h0, 32'hffffffff, 33'h3f);
        apb(1'b1, 12'h010, 32'h0, 32'h0, 33'h100000000);
        apb(1'b0, 12'h000, 32'h0, 32'hffffffff, 33'h3f);
        // second reset must restore the defaults
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 12'h000, 32'h0, 32'hffffffff, 33'h16);
    endtask
    task automatic t_modes();
        logic e;
        for (int i = 0; i < 16; i++) begin
            mode <= i[1:0];
            sleep_req <= i[3];
            apb(1'b1, 12'h000, {31'h0, i[2]}, 32'h0, 33'h0);
            repeat (3) @(posedge clk);
            e = i[1] ? (i[0] | !i[3]) : (i[0] & i[2]);
            check({32'h0, active}, {32'h0, e});
        end
    endtask
    task automatic t_sleep_wake();
        int n = 0;
        apb(1'b1, 12'h00c, 32'h2, 32'h0, 33'h0);
        while (wake !== 1'b1 && n < 260000) begin
            @(posedge clk);
            n++;
        end
        check({32'h0, wake}, 33'h1);
        // 32 slow ticks of 8064 cycles since the mode change
        check({32'h0, n > 249000}, 33'h1);
        sleep_req <= 1'b0;
        @(posedge clk);
        check({29'h0, wrst, to_f, pd_f, drst}, 33'h6);
        check({32'h0, irq}, 33'h1);
        apb(1'b0, 12'h008, 32'h0, 32'h2, 33'h2);
        check({32'h0, irq}, 33'h0);
        apb(1'b0, 12'h004, 32'h0, 32'hffffffff, 33'h26);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        repeat (3) @(posedge clk);
        check({31'h0, to_f, pd_f}, 33'h0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_modes();
        t_sleep_wake();
        finish_test();
    end
    initial begin
        #1200000;
        n_fail++;
        finish_test();
    end
endmodule // tb_top
